// >>> rtl/tlf_regs.svh
// register offsets, field positions, reset values and constants
// assumes inclusion by the transmit length and fifo port block only
`ifndef TLF_REGS_SVH
`define TLF_REGS_SVH
`define TLF_ADDR_TX_HM 6'h3D
`define TLF_ADDR_TX_LP 6'h3E
`define TLF_ADDR_FIFO 6'h3F
`define TLF_ADDR_FSTAT 6'h39
`define TLF_RST_TX_HM 8'h00
`define TLF_RST_TX_LP 8'h00
`define TLF_LP_CNT_MSB 7
`define TLF_LP_CNT_LSB 4
`define TLF_LP_BITS_MSB 3
`define TLF_LP_BITS_LSB 1
`define TLF_LP_RSV_BIT 0
`define TLF_FIFO_DEPTH 6'h30
`define TLF_FIFO_LAST 6'h2F
`define TLF_FILL_EMPTY 5'h1F
`define TLF_FILL_SAT 5'h1E
`define TLF_CMD_TX_A 8'h90
`define TLF_CMD_TX_B 8'h91
`define TLF_HDR_CMD_BIT 7
`define TLF_HDR_READ_BIT 6
`define TLF_FULL_BYTE_BITS 4'h8
`endif

// >>> rtl/tlf_pkg.sv
// types shared by the transmit length and fifo port block
// assumes nothing beyond a systemverilog compiler
package tlf_pkg;
  typedef enum logic [2:0] {
    TLF_IDLE = 3'b001,
    TLF_SEND = 3'b010,
    TLF_PART = 3'b100
  } tlf_state_type;

  typedef struct packed {
    logic [7:0] data;
    logic [3:0] bits;
    logic last;
  } tlf_word_type;
endpackage : tlf_pkg

// >>> rtl/tlf_tx_fifo_port.sv
// transmit length registers, 2 x 24 byte cyclic fifo and its serial port
// assumes serial pins already synchronous to clock; one clock domain
`timescale 1ns/1ps
`include "tlf_regs.svh"
module tlf_tx_fifo_port import tlf_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // serial host port
  input wire logic select_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  // transmit word stream
  output tlf_word_type tx_word,
  output logic tx_valid,
  input wire logic tx_ready
);
  logic sclk_q_ff;
  logic [2:0] bit_cnt_ff;
  logic [6:0] rx_sh_ff;
  logic [7:0] tx_sh_ff;
  logic first_ff;
  logic rd_ff;
  logic cmd_ff;
  logic [5:0] addr_ff;
  logic [7:0] len_hm_ff;
  logic [7:0] len_lp_ff;
  logic [7:0] mem [0:47];
  logic [5:0] wr_ptr_ff;
  logic [5:0] rd_ptr_ff;
  logic [5:0] fill_ff;
  tlf_state_type state_ff;
  tlf_state_type nxt_state;
  logic [11:0] remain_ff;
  logic [1:0] buf_cnt_ff;
  tlf_word_type e1_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic byte_done;
  logic [7:0] rx_byte;
  logic hdr_byte;
  logic hdr_read;
  logic start_tx;
  logic data_wr;
  logic load_rd;
  logic [5:0] rd_addr;
  logic spi_pop;
  logic spi_push;
  logic tx_take;
  logic fifo_pop;
  logic [7:0] rd_data;
  logic [4:0] fill_code;
  tlf_word_type in_word;
  logic out_pop;
  logic buf_ready;

  assign sclk_rise = sclk & ~sclk_q_ff & ~select_n;
  assign sclk_fall = ~sclk & sclk_q_ff & ~select_n;
  assign byte_done = sclk_rise & (bit_cnt_ff == 3'h7);
  assign rx_byte = {rx_sh_ff, mosi};
  assign hdr_byte = byte_done & first_ff;
  assign hdr_read = hdr_byte & ~rx_byte[`TLF_HDR_CMD_BIT]
                  & rx_byte[`TLF_HDR_READ_BIT];
  assign start_tx = hdr_byte & ((rx_byte == `TLF_CMD_TX_A)
                  | (rx_byte == `TLF_CMD_TX_B));
  assign data_wr = byte_done & ~first_ff & ~rd_ff & ~cmd_ff;
  assign load_rd = hdr_read | (byte_done & ~first_ff & rd_ff);
  assign rd_addr = hdr_read ? rx_byte[5:0] : addr_ff;
  assign spi_pop = load_rd & (rd_addr == `TLF_ADDR_FIFO)
                 & (fill_ff != 6'h00);
  assign spi_push = data_wr & (addr_ff == `TLF_ADDR_FIFO)
                  & (fill_ff != `TLF_FIFO_DEPTH);
  // host access wins the read pointer; transmit waits one cycle
  assign tx_take = (((state_ff == TLF_SEND) & (remain_ff != 12'h000))
                 | (state_ff == TLF_PART)) & (fill_ff != 6'h00)
                 & buf_ready & ~spi_pop;
  assign fifo_pop = spi_pop | tx_take;
  assign out_pop = tx_valid & tx_ready;
  assign buf_ready = (buf_cnt_ff != 2'h2);

  always_comb begin
    if (fill_ff == 6'h00) begin
      fill_code = `TLF_FILL_EMPTY;
    end else if (fill_ff >= {1'b0, `TLF_FILL_SAT}) begin
      fill_code = `TLF_FILL_SAT;
    end else begin
      fill_code = fill_ff[4:0];
    end
  end

  always_comb begin
    case (rd_addr)
      `TLF_ADDR_TX_HM: rd_data = len_hm_ff;
      `TLF_ADDR_TX_LP: rd_data = {len_lp_ff[7:1], 1'b0};
      `TLF_ADDR_FIFO: rd_data = spi_pop ? mem[rd_ptr_ff] : 8'h00;
      `TLF_ADDR_FSTAT: rd_data = {3'h0, fill_code};
      default: rd_data = 8'h00;
    endcase
  end

  // serial bit and byte framing
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q_ff <= 1'b0;
      bit_cnt_ff <= 3'h0;
      rx_sh_ff <= 7'h00;
      first_ff <= 1'b1;
      rd_ff <= 1'b0;
      cmd_ff <= 1'b0;
      addr_ff <= 6'h00;
    end else begin
      sclk_q_ff <= sclk;
      if (select_n) begin
        bit_cnt_ff <= 3'h0;
        first_ff <= 1'b1;
        rd_ff <= 1'b0;
        cmd_ff <= 1'b0;
      end else if (sclk_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        rx_sh_ff <= rx_byte[6:0];
        if (hdr_byte) begin
          first_ff <= 1'b0;
          cmd_ff <= rx_byte[`TLF_HDR_CMD_BIT];
          rd_ff <= rx_byte[`TLF_HDR_READ_BIT];
          addr_ff <= rx_byte[5:0];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_sh_ff <= 8'h00;
      miso <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= select_n;
      if (load_rd) begin
        tx_sh_ff <= rd_data;
      end else if (sclk_fall) begin
        miso <= tx_sh_ff[7];
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
      end
    end
  end

  // length registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      len_hm_ff <= `TLF_RST_TX_HM;
      len_lp_ff <= `TLF_RST_TX_LP;
    end else if (data_wr) begin
      if (addr_ff == `TLF_ADDR_TX_HM) begin
        len_hm_ff <= rx_byte;
      end
      if (addr_ff == `TLF_ADDR_TX_LP) begin
        len_lp_ff <= {rx_byte[7:1], 1'b0};
      end
    end
  end

  // cyclic storage, wraps after both banks
  always_ff @(posedge clock) begin
    if (spi_push) begin
      mem[wr_ptr_ff] <= rx_byte;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= 6'h00;
      rd_ptr_ff <= 6'h00;
      fill_ff <= 6'h00;
    end else begin
      if (spi_push) begin
        wr_ptr_ff <= (wr_ptr_ff == `TLF_FIFO_LAST) ? 6'h00
                   : wr_ptr_ff + 6'h01;
      end
      if (fifo_pop) begin
        rd_ptr_ff <= (rd_ptr_ff == `TLF_FIFO_LAST) ? 6'h00
                   : rd_ptr_ff + 6'h01;
      end
      if (spi_push & ~fifo_pop) begin
        fill_ff <= fill_ff + 6'h01;
      end else if (fifo_pop & ~spi_push) begin
        fill_ff <= fill_ff - 6'h01;
      end
    end
  end

  // partial byte carries only its bits
  always_comb begin
    in_word.data = mem[rd_ptr_ff];
    if (state_ff == TLF_PART) begin
      in_word.bits = {1'b0, len_lp_ff[`TLF_LP_BITS_MSB:`TLF_LP_BITS_LSB]};
      in_word.last = 1'b1;
    end else begin
      in_word.bits = `TLF_FULL_BYTE_BITS;
      in_word.last = (remain_ff == 12'h001)
                   & (len_lp_ff[`TLF_LP_BITS_MSB:`TLF_LP_BITS_LSB] == 3'h0);
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TLF_IDLE: begin
        if (start_tx) begin
          nxt_state = TLF_SEND;
        end
      end
      TLF_SEND: begin
        if (remain_ff == 12'h000) begin
          nxt_state = (len_lp_ff[`TLF_LP_BITS_MSB:`TLF_LP_BITS_LSB]
                      != 3'h0) ? TLF_PART : TLF_IDLE;
        end
      end
      TLF_PART: begin
        if (tx_take) begin
          nxt_state = TLF_IDLE;
        end
      end
      default: nxt_state = TLF_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= TLF_IDLE;
      remain_ff <= 12'h000;
    end else begin
      state_ff <= nxt_state;
      if ((state_ff == TLF_IDLE) & start_tx) begin
        remain_ff <= {len_hm_ff, len_lp_ff[`TLF_LP_CNT_MSB:`TLF_LP_CNT_LSB]};
      end else if (tx_take & (state_ff == TLF_SEND)) begin
        remain_ff <= remain_ff - 12'h001;
      end
    end
  end

  // two-entry buffer; the head entry is the output register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      buf_cnt_ff <= 2'h0;
      tx_word <= '0;
      e1_ff <= '0;
      tx_valid <= 1'b0;
    end else begin
      case ({tx_take, out_pop})
        2'b10: begin
          if (buf_cnt_ff == 2'h0) begin
            tx_word <= in_word;
          end else begin
            e1_ff <= in_word;
          end
          buf_cnt_ff <= buf_cnt_ff + 2'h1;
          tx_valid <= 1'b1;
        end
        2'b01: begin
          tx_word <= e1_ff;
          buf_cnt_ff <= buf_cnt_ff - 2'h1;
          tx_valid <= (buf_cnt_ff == 2'h2);
        end
        2'b11: begin
          if (buf_cnt_ff == 2'h1) begin
            tx_word <= in_word;
          end else begin
            tx_word <= e1_ff;
            e1_ff <= in_word;
          end
        end
        default: begin
          tx_valid <= (buf_cnt_ff != 2'h0);
        end
      endcase
    end
  end
endmodule : tlf_tx_fifo_port

// >>> verification/tlf_port_properties.sv
// checker for the transmit length and fifo port top
// assumes bind onto tlf_tx_fifo_port, one clock domain
`timescale 1ns/1ps
module tlf_port_properties import tlf_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // serial host port
  input wire logic select_n,
  input wire logic miso_oe_n,
  // word stream
  input wire tlf_word_type tx_word,
  input wire logic tx_valid,
  input wire logic tx_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  oe_on_a: assert property (!select_n ##1 !select_n |-> !miso_oe_n)
    else $error("miso not driven while selected");
  oe_off_a: assert property (select_n |=> miso_oe_n)
    else $error("miso driven while deselected");
  stall_valid_a: assert property (
    tx_valid && !tx_ready |=> tx_valid)
    else $error("word dropped under stall");
  stall_data_a: assert property (
    tx_valid && !tx_ready |=> $stable(tx_word))
    else $error("word changed under stall");
  full_bits_a: assert property (
    tx_valid && !tx_word.last |-> tx_word.bits == 4'h8)
    else $error("inner word not a full byte");
  last_bits_a: assert property (
    tx_valid && tx_word.last |-> tx_word.bits inside {[4'h1:4'h8]})
    else $error("bad bit count on last word");
  last_end_a: assert property (
    tx_valid && tx_ready && tx_word.last |=> !tx_valid [*2])
    else $error("word after last of frame");
  reset_idle_a: assert property (
    $rose(reset_n) |-> !tx_valid && miso_oe_n)
    else $error("outputs busy after reset");
endmodule : tlf_port_properties

bind tlf_tx_fifo_port tlf_port_properties i_props (
  .clock(clock), .reset_n(reset_n), .select_n(select_n),
  .miso_oe_n(miso_oe_n), .tx_word(tx_word), .tx_valid(tx_valid),
  .tx_ready(tx_ready));

// >>> verification/tlf_tx_sink.sv
// far-side word receiver model with optional stalling
// assumes its inputs change on the falling clock edge, like the bench
`timescale 1ns/1ps
module tlf_tx_sink (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // stream
  input wire logic stall,
  output logic tx_ready
);
  logic [1:0] cnt_ff;
  // ready one cycle in four keeps both buffer entries busy
  always @(negedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      tx_ready <= !stall || (cnt_ff == 2'h3);
    end
  end
endmodule : tlf_tx_sink

// >>> verification/tb_tlf_tx_fifo_port.sv
// bench for tlf_tx_fifo_port: registers, fifo and word stream
// assumes sink model and checker compiled before it
`timescale 1ns/1ps
module tb_tlf_tx_fifo_port import tlf_pkg::*; ;
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] d;
    logic w;
    logic [7:0] e;
  } tlf_row_type;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic select_n = 1'b1, sclk = 1'b0, mosi = 1'b0, stall = 1'b0;
  logic miso, miso_oe_n, tx_valid, tx_ready, so_last = 1'b0;
  logic [7:0] r;
  tlf_word_type tx_word;
  tlf_word_type got[$];
  int miscompares = 0, checks = 0, cycles = 0;
  // released line shows the inverse of its last driven value
  wire logic so_w = miso_oe_n ? ~so_last : miso;
  tlf_row_type rows [7] = '{'{6'h3D, 8'h00, 1'b0, 8'h00},
    '{6'h3E, 8'h00, 1'b0, 8'h00}, '{6'h39, 8'h00, 1'b0, 8'h1F},
    '{6'h3D, 8'hA5, 1'b1, 8'hA5}, '{6'h3E, 8'hFF, 1'b1, 8'hFE},
    '{6'h20, 8'h5A, 1'b1, 8'h00}, '{6'h3F, 8'h00, 1'b0, 8'h00}};
  tlf_word_type exp_w [3] = '{'{8'h11, 4'h8, 1'b0},
    '{8'h22, 4'h8, 1'b0}, '{8'h33, 4'h3, 1'b1}};
  always #5 clock = ~clock;
  tlf_tx_fifo_port i_dut (.clock(clock), .reset_n(reset_n),
    .select_n(select_n), .sclk(sclk), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n), .tx_word(tx_word), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  tlf_tx_sink i_sink (.clock(clock), .reset_n(reset_n), .stall(stall),
    .tx_ready(tx_ready));
  always @(posedge clock) begin
    if (!miso_oe_n) so_last <= miso;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_word);
  end
  task complete_run;
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  always @(negedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run;
    end
  end
  task check8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t byte %h want %h", $time, g, e);
    end
  endtask : check8
  task checkw(input tlf_word_type g, input tlf_word_type e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t word %h want %h", $time, g, e);
    end
  endtask : checkw
  task tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task xfer(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      sclk = 1'b0;
      tick(2);
      sclk = 1'b1;
      tick(1);
      r[i] = so_w;
      tick(1);
    end
  endtask : xfer
  task open(input logic [7:0] h);
    select_n = 1'b0;
    tick(2);
    xfer(h);
  endtask : open
  task close;
    sclk = 1'b0;
    tick(2);
    select_n = 1'b1;
    tick(3);
  endtask : close
  task wr(input logic [5:0] a, input logic [7:0] d);
    open({2'b00, a});
    xfer(d);
    close;
  endtask : wr
  task rd(input logic [5:0] a);
    open({2'b01, a});
    xfer(8'h00);
    close;
  endtask : rd
  task cmd(input logic [7:0] c);
    open(c);
    close;
  endtask : cmd
  task waitn(input int k);
    repeat (300) if (got.size() < k) tick(1);
  endtask : waitn
  initial begin
    tick(10);
    reset_n = 1'b1;
    tick(2);
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      rd(rows[k].a);
      check8(r, rows[k].e);
    end
    // overfill by one, then drain past empty
    open(8'h3F);
    for (int i = 0; i < 49; i++) xfer(8'(i + 1));
    close;
    rd(6'h39);
    check8(r, 8'h1E);
    open(8'h7F);
    for (int i = 0; i < 49; i++) begin
      xfer(8'h00);
      check8(r, (i < 48) ? 8'(i + 1) : 8'h00);
    end
    close;
    rd(6'h39);
    check8(r, 8'h1F);
    wr(6'h3D, 8'h00);
    wr(6'h3E, 8'h26);
    open(8'h3F);
    xfer(8'h11);
    xfer(8'h22);
    xfer(8'h33);
    close;
    stall = 1'b1;
    cmd(8'h90);
    waitn(3);
    check8(8'(got.size()), 8'h03);
    foreach (exp_w[k]) checkw(got[k], exp_w[k]);
    wr(6'h3E, 8'h10);
    wr(6'h3F, 8'h44);
    cmd(8'h92);
    tick(60);
    check8(8'(got.size()), 8'h03);
    stall = 1'b0;
    cmd(8'h91);
    waitn(4);
    check8(8'(got.size()), 8'h04);
    check8(got[3].data, 8'h44);
    check8({4'h0, got[3].bits}, 8'h08);
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(2);
    rd(6'h3E);
    check8(r, 8'h00);
    complete_run;
  end
endmodule : tb_tlf_tx_fifo_port
